// File: dls_params.svh
`ifndef DLS_PARAMS_SVH
`define DLS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define DLS_OFS_CTRL        8'h00
`define DLS_OFS_INNER_LO    8'h04
`define DLS_OFS_INNER_HI    8'h08
`define DLS_OFS_OUTER_LO    8'h0c
`define DLS_OFS_OUTER_HI    8'h10
`define DLS_OFS_PULSE_TIME  8'h14
`define DLS_OFS_RESULT      8'h18
`define DLS_OFS_CLEAR       8'h1c
`define DLS_OFS_IRQ_STATUS  8'h20
`define DLS_OFS_IRQ_MASK    8'h24
`define DLS_OFS_READING     8'h28

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define DLS_CTRL_INNER_EN   0
`define DLS_CTRL_OUTER_EN   1
`define DLS_CTRL_OUT_EN     2
`define DLS_CTRL_POL_LOW    3
`define DLS_CTRL_PULSE_EN   4
`define DLS_CTRL_IN_AUTO    5
`define DLS_CTRL_OUT_AUTO   6
`define DLS_CTRL_BEEP_IN    7
`define DLS_CTRL_W          8
`define DLS_CTRL_RST        8'h60

// ----------------------------------------------------------------
// Reset values of the bounds
// ----------------------------------------------------------------
`define DLS_INNER_HI_RST    32'h0000_0001
`define DLS_INNER_LO_RST    32'hffff_ffff
`define DLS_OUTER_HI_RST    32'h0000_0002
`define DLS_OUTER_LO_RST    32'hffff_fffe

// ----------------------------------------------------------------
// Pulse timing: pulse length is held in milliseconds
// ----------------------------------------------------------------
`define DLS_PULSE_W         27
`define DLS_PULSE_MIN_MS    27'd1
`define DLS_PULSE_MAX_MS    27'd99999999
`define DLS_PULSE_RST_MS    27'd2
`define DLS_MS_IN_NS        1000000
`define DLS_CLK_PERIOD_NS   4
`define DLS_MS_TICK_CYCLES  ((`DLS_MS_IN_NS + `DLS_CLK_PERIOD_NS - 1) / `DLS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define DLS_IRQ_READING     0
`define DLS_IRQ_INNER_FAIL  1
`define DLS_IRQ_OUTER_FAIL  2
`define DLS_IRQ_W           3

`endif

// File: dls_pkg.sv
package dls_pkg;
   // Bin assignment of the latched results
   typedef enum logic [1:0] {
      DLS_BIN_NONE,
      DLS_BIN_1,
      DLS_BIN_2,
      DLS_BIN_3
   } dls_bin_t;

   typedef logic signed [31:0] dls_reading_t;
   typedef logic [4:0]         dls_outs_t;
endpackage

// File: dls_timer_if.sv
`timescale 1ns/1ns
`include "dls_params.svh"
interface dls_timer_if;
   logic                    start;
   logic [`DLS_PULSE_W-1:0] ms_count;
   logic                    busy;
   logic                    done;

   modport ctl (output start, output ms_count, input busy, input done);
   modport tmr (input start, input ms_count, output busy, output done);
endinterface

// File: dls_pulse_timer.sv
`timescale 1ns/1ns
`include "dls_params.svh"
module dls_pulse_timer #(
   parameter int TICK_CYCLES = `DLS_MS_TICK_CYCLES
) (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  wire logic   ce_i,
   dls_timer_if.tmr    tif
);
   import dls_pkg::*;

   localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   logic [PRE_W-1:0]        pre;
   logic [`DLS_PULSE_W-1:0] cnt;

   // ----------------------------------------------------------------
   // Millisecond prescaler and pulse length counter
   // ----------------------------------------------------------------
   // A new start restarts the count, so back to back fails stretch the pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre      <= '0;
         cnt      <= '0;
         tif.busy <= 1'b0;
         tif.done <= 1'b0;
      end else if (ce_i) begin
         tif.done <= 1'b0;
         if (tif.start) begin
            tif.busy <= 1'b1;
            cnt      <= tif.ms_count;
            pre      <= '0;
         end else if (tif.busy) begin
            if (pre == PRE_W'(TICK_CYCLES - 1)) begin
               pre <= '0;
               if (cnt <= `DLS_PULSE_W'(1)) begin
                  tif.busy <= 1'b0;
                  tif.done <= 1'b1;  // One-cycle end marker
               end else begin
                  cnt <= cnt - `DLS_PULSE_W'(1);
               end
            end else begin
               pre <= pre + PRE_W'(1);
            end
         end
      end
   end
endmodule // dls_pulse_timer

// File: dls_limit_sort.sv
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ns
`include "dls_params.svh"
module dls_limit_sort #(
   parameter int MS_TICK_CYCLES = `DLS_MS_TICK_CYCLES
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                ce_i,
   // Wishbone classic slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output      logic [31:0]         wb_dat_o,
   output      logic                wb_ack_o,
   // Measurement side
   input  wire dls_pkg::dls_reading_t reading_i,
   input  wire logic                reading_valid_i,
   input  wire logic                idle_i,
   // Handler outputs, bit 0 is output 1
   output      dls_pkg::dls_outs_t  dout_o,
   // Beeper and message
   output      logic                beep_normal_o,
   output      logic                beep_harsh_o,
   output      logic                msg_in_o,
   output      logic                msg_one_o,
   output      logic                irq_o
);
   import dls_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [`DLS_CTRL_W-1:0]  ctrl;
   dls_reading_t            inner_lower_bound;
   dls_reading_t            inner_upper_bound;
   dls_reading_t            outer_lower_bound;
   dls_reading_t            outer_upper_bound;
   logic [`DLS_PULSE_W-1:0] pulse_ms;
   dls_reading_t            last_reading;
   logic                    inner_fail;
   logic                    outer_fail;
   logic [3:0]              fail_detail;
   logic [`DLS_IRQ_W-1:0]   irq_status;
   logic [`DLS_IRQ_W-1:0]   irq_mask;
   dls_outs_t               act;
   logic                    idle_q;

   logic                    wr_ok;
   logic                    rd_req;
   logic [31:0]             next_rdata;
   logic                    in_lo_f;
   logic                    in_hi_f;
   logic                    out_lo_f;
   logic                    out_hi_f;
   logic                    in_f;
   logic                    out_f;
   logic                    idle_entry;
   logic                    clr_inner;
   logic                    clr_outer;
   logic                    polarity_low_true;
   dls_outs_t               next_act;
   dls_outs_t               hit;
   dls_bin_t                bin;
   logic [`DLS_IRQ_W-1:0]   irq_set;
   logic [`DLS_IRQ_W-1:0]   irq_clr;
   logic [`DLS_PULSE_W-1:0] wr_pulse;
   logic [31:0]             wr_merged;

   dls_timer_if tif ();

   dls_pulse_timer #(
      .TICK_CYCLES (MS_TICK_CYCLES)
   ) u_timer (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .tif   (tif)
   );

   // Byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Wishbone handshake
   // ----------------------------------------------------------------
   // Writes land on the edge where the master samples ack; a request held
   // past ack is acked again and writes again two cycles later
   assign rd_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ok  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= rd_req;
         if (rd_req) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

   // Read mux; unmapped offsets read as zero and still acknowledge
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (wb_adr_i)
         `DLS_OFS_CTRL:       next_rdata[`DLS_CTRL_W-1:0] = ctrl;
         `DLS_OFS_INNER_LO:   next_rdata = inner_lower_bound;
         `DLS_OFS_INNER_HI:   next_rdata = inner_upper_bound;
         `DLS_OFS_OUTER_LO:   next_rdata = outer_lower_bound;
         `DLS_OFS_OUTER_HI:   next_rdata = outer_upper_bound;
         `DLS_OFS_PULSE_TIME: next_rdata[`DLS_PULSE_W-1:0] = pulse_ms;
         `DLS_OFS_RESULT:     next_rdata[12:0] = {act, fail_detail, bin, outer_fail, inner_fail};
         `DLS_OFS_IRQ_STATUS: next_rdata[`DLS_IRQ_W-1:0] = irq_status;
         `DLS_OFS_IRQ_MASK:   next_rdata[`DLS_IRQ_W-1:0] = irq_mask;
         `DLS_OFS_READING:    next_rdata = last_reading;
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl              <= `DLS_CTRL_RST;
         inner_lower_bound <= `DLS_INNER_LO_RST;
         inner_upper_bound <= `DLS_INNER_HI_RST;
         outer_lower_bound <= `DLS_OUTER_LO_RST;
         outer_upper_bound <= `DLS_OUTER_HI_RST;
      end else if (ce_i && wr_ok) begin
         unique case (wb_adr_i)
            `DLS_OFS_CTRL:     ctrl <= wb_sel_i[0] ? wb_dat_i[`DLS_CTRL_W-1:0] : ctrl;
            `DLS_OFS_INNER_LO: inner_lower_bound <= merge(inner_lower_bound, wb_dat_i, wb_sel_i);
            `DLS_OFS_INNER_HI: inner_upper_bound <= merge(inner_upper_bound, wb_dat_i, wb_sel_i);
            `DLS_OFS_OUTER_LO: outer_lower_bound <= merge(outer_lower_bound, wb_dat_i, wb_sel_i);
            `DLS_OFS_OUTER_HI: outer_upper_bound <= merge(outer_upper_bound, wb_dat_i, wb_sel_i);
            default: ;
         endcase
      end
   end

   // Requested pulse length after byte merge; the clamp looks at all 32
   // bits, so a large write saturates instead of wrapping to a short pulse
   assign wr_merged = merge({5'h00, pulse_ms}, wb_dat_i, wb_sel_i);
   assign wr_pulse  = wr_merged[`DLS_PULSE_W-1:0];

   // pulse range clamp
   // Out-of-range lengths are clamped rather than refused, so software
   // always reads back the length actually in use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_ms <= `DLS_PULSE_RST_MS;
      end else if (ce_i && wr_ok && wb_adr_i == `DLS_OFS_PULSE_TIME) begin
         if (wr_merged < 32'(`DLS_PULSE_MIN_MS)) begin
            pulse_ms <= `DLS_PULSE_MIN_MS;
         end else if (wr_merged > 32'(`DLS_PULSE_MAX_MS)) begin
            pulse_ms <= `DLS_PULSE_MAX_MS;
         end else begin
            pulse_ms <= wr_pulse;
         end
      end
   end

   assign polarity_low_true = ctrl[`DLS_CTRL_POL_LOW];

   // ----------------------------------------------------------------
   // Limit comparisons
   // ----------------------------------------------------------------
   // independent pair tests
   // reaching a bound fails
   // A disabled pair never fails, so it cannot push a reading into a bin
   assign in_lo_f  = ctrl[`DLS_CTRL_INNER_EN] & (reading_i <= inner_lower_bound);
   assign in_hi_f  = ctrl[`DLS_CTRL_INNER_EN] & (reading_i >= inner_upper_bound);
   assign out_lo_f = ctrl[`DLS_CTRL_OUTER_EN] & (reading_i <= outer_lower_bound);
   assign out_hi_f = ctrl[`DLS_CTRL_OUTER_EN] & (reading_i >= outer_upper_bound);
   assign in_f     = in_lo_f | in_hi_f;
   assign out_f    = out_lo_f | out_hi_f;

   assign hit = {in_f | out_f, out_hi_f, out_lo_f, in_hi_f, in_lo_f};

   // ----------------------------------------------------------------
   // Fail latches and clearing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_q <= 1'b0;
      end else if (ce_i) begin
         idle_q <= idle_i;
      end
   end

   assign idle_entry = idle_i & ~idle_q;

   assign clr_inner = (wr_ok && wb_adr_i == `DLS_OFS_CLEAR && wb_sel_i[0] && wb_dat_i[0])
                    | (ctrl[`DLS_CTRL_IN_AUTO] & idle_entry);
   assign clr_outer = (wr_ok && wb_adr_i == `DLS_OFS_CLEAR && wb_sel_i[0] && wb_dat_i[1])
                    | (ctrl[`DLS_CTRL_OUT_AUTO] & idle_entry);

   // single-cycle latch update
   // A fail in the same cycle as a clear wins; stale fails stay until cleared
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inner_fail   <= 1'b0;
         outer_fail   <= 1'b0;
         fail_detail  <= 4'h0;
         last_reading <= 32'h0000_0000;
      end else if (ce_i) begin
         inner_fail <= (reading_valid_i & in_f) | (inner_fail & ~clr_inner);
         outer_fail <= (reading_valid_i & out_f) | (outer_fail & ~clr_outer);
         if (reading_valid_i) begin
            last_reading <= reading_i;
            fail_detail  <= hit[3:0];
         end
      end
   end

   // a stale fail carries into the bin
   always_comb begin
      if (outer_fail) begin
         bin = DLS_BIN_3;
      end else if (inner_fail) begin
         bin = DLS_BIN_2;
      end else if (ctrl[`DLS_CTRL_INNER_EN] | ctrl[`DLS_CTRL_OUTER_EN]) begin
         bin = DLS_BIN_1;
      end else begin
         bin = DLS_BIN_NONE;
      end
   end

   // ----------------------------------------------------------------
   // Handler outputs
   // ----------------------------------------------------------------
   // update only while enabled
   always_comb begin
      next_act = act;
      if (ctrl[`DLS_CTRL_OUT_EN] && reading_valid_i) begin
         next_act = hit;
      end else if (ctrl[`DLS_CTRL_PULSE_EN] && tif.done) begin
         next_act = 5'h00;
      end
   end

   assign tif.start    = ctrl[`DLS_CTRL_OUT_EN] & ctrl[`DLS_CTRL_PULSE_EN]
                       & reading_valid_i & (|hit);
   assign tif.ms_count = pulse_ms;

   // polarity applied at the pin
   // Pins come straight from a flop; the logical pattern is kept apart
   // so a polarity change flips idle pins without touching results
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act    <= 5'h00;
         dout_o <= 5'h00;
      end else if (ce_i) begin
         act    <= next_act;
         dout_o <= next_act ^ {5{polarity_low_true}};
      end
   end

   // ----------------------------------------------------------------
   // Beeper and message
   // ----------------------------------------------------------------
   // inside-beep tones
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         beep_normal_o <= 1'b0;
         beep_harsh_o  <= 1'b0;
         msg_in_o      <= 1'b0;
         msg_one_o     <= 1'b0;
      end else if (ce_i) begin
         beep_normal_o <= 1'b0;
         beep_harsh_o  <= 1'b0;
         if (reading_valid_i) begin
            if (ctrl[`DLS_CTRL_BEEP_IN]) begin
               beep_normal_o <= ~in_f;
               beep_harsh_o  <= in_f & ~out_f;
            end
            msg_in_o  <= ~in_f & ~out_f;
            msg_one_o <= in_f & ~out_f;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign irq_set = {reading_valid_i & out_f, reading_valid_i & in_f, reading_valid_i};
   assign irq_clr = (wr_ok && wb_adr_i == `DLS_OFS_IRQ_STATUS && wb_sel_i[0])
                  ? wb_dat_i[`DLS_IRQ_W-1:0] : '0;

   // Sticky status, write one to clear; a new event beats its clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= '0;
         irq_mask   <= '0;
         irq_o      <= 1'b0;
      end else if (ce_i) begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_ok && wb_adr_i == `DLS_OFS_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask <= wb_dat_i[`DLS_IRQ_W-1:0];
         end
         irq_o <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
      end
   end

endmodule // dls_limit_sort

// File: dls_handler_model.sv
`timescale 1ns/1ns
module dls_handler_model (
   input  wire logic               clk_i,
   input  wire logic               pol_low_i,
   input  wire dls_pkg::dls_outs_t dout_i,
   output logic [1:0]              bin_o
);
   import dls_pkg::*;
   dls_outs_t act;

   // Undo the pin polarity so the handler sees logical outputs
   assign act = dout_i ^ {5{pol_low_i}};

   always_ff @(posedge clk_i) begin
      if (!act[4]) begin
         bin_o <= 2'h1;
      end else if (act[2] || act[3]) begin
         bin_o <= 2'h3;
      end else begin
         bin_o <= 2'h2;
      end
   end
endmodule // dls_handler_model

// File: dls_limit_sort_checker.sv
`timescale 1ns/1ns
`include "dls_params.svh"
module dls_limit_sort_checker (
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_we_i,
   input wire logic [7:0]         wb_adr_i,
   input wire logic [3:0]         wb_sel_i,
   input wire logic [31:0]        wb_dat_i,
   input wire logic               wb_ack_o,
   input wire logic               reading_valid_i,
   input wire dls_pkg::dls_outs_t dout_o,
   input wire logic               beep_normal_o,
   input wire logic               beep_harsh_o,
   input wire logic               msg_in_o,
   input wire logic               msg_one_o,
   input wire logic               irq_o
);
   import dls_pkg::*;
   logic      pol_q;
   logic      pol_d;
   dls_outs_t act;

   // Pins follow a polarity write one cycle late, so the shadow lags too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pol_q <= 1'b0;
         pol_d <= 1'b0;
      end else begin
         if (wb_ack_o && wb_we_i && wb_adr_i == `DLS_OFS_CTRL && wb_sel_i[0])
            pol_q <= wb_dat_i[`DLS_CTRL_POL_LOW];
         pol_d <= pol_q;
      end
   end
   assign act = dout_o ^ {5{pol_d}};

   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   a_req_acked: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_out5_any_fail: assert property (|act[3:0] |-> act[4])
      else $error("fail pin without output 5");
   a_outer_pins_nested: assert property (!(act[2] && !act[0]) && !(act[3] && !act[1]))
      else $error("outer pin without inner pin");
   a_beep_excl: assert property (!(beep_normal_o && beep_harsh_o))
      else $error("both tones at once");
   a_beep_cause: assert property (beep_normal_o || beep_harsh_o |-> $past(reading_valid_i))
      else $error("tone without reading");
   a_msg_cause: assert property ($changed(msg_in_o) || $changed(msg_one_o)
      |-> $past(reading_valid_i))
      else $error("message changed without reading");
   a_msg_excl: assert property (!(msg_in_o && msg_one_o))
      else $error("both messages at once");
   a_reset_quiet: assert property ($fell(rst_i) |-> dout_o == 5'h00 && !irq_o)
      else $error("outputs active after reset");

   c_bin3_high: cover property (reading_valid_i ##1 act == 5'h1a);
   c_harsh: cover property (beep_harsh_o);
   c_irq: cover property (irq_o);
   c_read: cover property (wb_ack_o && !wb_we_i);
endmodule // dls_limit_sort_checker

bind dls_limit_sort dls_limit_sort_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .reading_valid_i(reading_valid_i), .dout_o(dout_o), .beep_normal_o(beep_normal_o),
   .beep_harsh_o(beep_harsh_o), .msg_in_o(msg_in_o), .msg_one_o(msg_one_o), .irq_o(irq_o));

// File: dls_limit_sort_tb.sv
`timescale 1ns/1ns
`include "dls_params.svh"
module dls_limit_sort_tb;
   import dls_pkg::*;
   logic         clk_i = 0, rst_i = 1, ce_i = 1, cyc = 0, stb = 0, we = 0;
   logic         rv = 0, idle = 0, pol = 0, ack, bn, bh, mi, mo, irq, a;
   logic [7:0]   adr = 8'h00;
   logic [3:0]   sel = 4'hf;
   logic [31:0]  wdat = 32'h0, rdat, dat_o;
   logic [1:0]   hbin;
   dls_reading_t rd = 32'h0;
   dls_outs_t    dout;
   int           mismatches = 0, n_compared = 0, cyc_n = 0;

   dls_limit_sort #(.MS_TICK_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .reading_i(rd),
      .reading_valid_i(rv), .idle_i(idle), .dout_o(dout), .beep_normal_o(bn),
      .beep_harsh_o(bh), .msg_in_o(mi), .msg_one_o(mo), .irq_o(irq));
   dls_handler_model u_hdl (.clk_i(clk_i), .pol_low_i(pol), .dout_i(dout), .bin_o(hbin));

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   initial forever #2 clk_i = ~clk_i;

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         mismatches++;
         tally_and_finish;
      end
   end

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic cycle; the leading edge wait leaves cyc low for a cycle
   task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d;
      // Ends once ack is seen high; the hang guard ends it if ack never comes
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask

   // One strobe; returns just after the taking edge has landed
   task automatic meas(input int v);
      @(posedge clk_i);
      rv <= 1'b1; rd <= v;
      @(posedge clk_i);
      rv <= 1'b0;
      #1;
   endtask

   task automatic idle_entry;
      @(posedge clk_i); idle <= 1'b1;
      @(posedge clk_i); idle <= 1'b0;
   endtask

   // Logical pins for bounds 99/101 inside 95/105; equality fails
   function automatic logic [4:0] pat(input int v);
      logic [4:0] p;
      p[0] = v <= 99; p[1] = v >= 101; p[2] = v <= 95; p[3] = v >= 105;
      p[4] = |p[3:0];
      return p;
   endfunction

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset;
      logic [7:0]  ad [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h2c, 8'h18, 8'h28};
      logic [31:0] ex [9] = '{32'h60, `DLS_INNER_LO_RST, `DLS_INNER_HI_RST,
         `DLS_OUTER_LO_RST, `DLS_OUTER_HI_RST, 32'h2, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 9; i++) begin
         bus(0, ad[i], 0);
         chk("reset_reg", rdat, ex[i]);
      end
      sel <= 4'h1;
      bus(1, `DLS_OFS_PULSE_TIME, 32'hffffffff);
      sel <= 4'hf;
      bus(0, `DLS_OFS_PULSE_TIME, 0);
      chk("pulse_lane0", rdat, 32'hff);
      bus(1, `DLS_OFS_PULSE_TIME, 0);
      bus(0, `DLS_OFS_PULSE_TIME, 0);
      chk("pulse_min", rdat, 32'h1);
      bus(1, `DLS_OFS_PULSE_TIME, 32'hffffffff);
      bus(0, `DLS_OFS_PULSE_TIME, 0);
      chk("pulse_max", rdat, 32'(`DLS_PULSE_MAX_MS));
      bus(1, `DLS_OFS_PULSE_TIME, 32'h0800_0000);
      bus(0, `DLS_OFS_PULSE_TIME, 0);
      chk("pulse_wide", rdat, 32'(`DLS_PULSE_MAX_MS));
      $display("test reset done");
   endtask

   task automatic t_bins;
      int v [7] = '{100, 99, 101, 96, 95, 105, 94};
      logic [4:0] p;
      logic [1:0] b;
      logic in_f, out_f;
      bus(1, `DLS_OFS_INNER_LO, 99);  bus(1, `DLS_OFS_INNER_HI, 101);
      bus(1, `DLS_OFS_OUTER_LO, 95);  bus(1, `DLS_OFS_OUTER_HI, 105);
      bus(1, `DLS_OFS_CTRL, 32'he7);
      for (int i = 0; i < 7; i++) begin
         p = pat(v[i]);
         in_f = p[0] | p[1];
         out_f = p[2] | p[3];
         b = !p[4] ? 2'h1 : (out_f ? 2'h3 : 2'h2);
         bus(1, `DLS_OFS_CLEAR, 32'h3);
         meas(v[i]);
         chk("dout", dout, p);
         chk("beep_normal", bn, !in_f);
         chk("beep_harsh", bh, in_f & !out_f);
         chk("msg", {mi, mo}, {!in_f, in_f & !out_f});
         bus(0, `DLS_OFS_RESULT, 0);
         chk("result", rdat[12:0], {p, p[3:0], b, out_f, in_f});
         chk("handler_bin", hbin, b);
      end
      $display("test bins done");
   endtask

   task automatic t_latch;
      bus(1, `DLS_OFS_CTRL, 32'h67);
      bus(1, `DLS_OFS_CLEAR, 32'h3);
      meas(101);
      meas(100);
      bus(0, `DLS_OFS_RESULT, 0);
      chk("fail_latched", rdat[1:0], 2'h1);
      idle_entry;
      bus(0, `DLS_OFS_RESULT, 0);
      chk("auto_clear", rdat[1:0], 2'h0);
      bus(1, `DLS_OFS_CTRL, 32'h07);
      meas(105);
      idle_entry;
      bus(0, `DLS_OFS_RESULT, 0);
      chk("no_auto", rdat[1:0], 2'h3);
      bus(1, `DLS_OFS_CLEAR, 32'h1);
      bus(0, `DLS_OFS_RESULT, 0);
      chk("clear_inner", rdat[1:0], 2'h2);
      bus(1, `DLS_OFS_CLEAR, 32'h2);
      bus(0, `DLS_OFS_RESULT, 0);
      chk("clear_outer", rdat[1:0], 2'h0);
      bus(1, `DLS_OFS_IRQ_MASK, 0);
      repeat (2) @(posedge clk_i);
      a = irq;
      bus(1, `DLS_OFS_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk_i);
      chk("irq_masked", a, 1'b0);
      chk("irq_unmasked", irq, 1'b1);
      bus(0, `DLS_OFS_IRQ_STATUS, 0);
      chk("irq_status", rdat[2:0], 3'h7);
      bus(1, `DLS_OFS_IRQ_STATUS, 32'h7);
      bus(0, `DLS_OFS_IRQ_STATUS, 0);
      chk("irq_w1c", rdat[2:0], 3'h0);
      repeat (2) @(posedge clk_i);
      chk("irq_low", irq, 1'b0);
      $display("test latch done");
   endtask

   task automatic t_pol;
      bus(1, `DLS_OFS_CTRL, 32'h6f);
      pol <= 1'b1;
      bus(1, `DLS_OFS_CLEAR, 32'h3);
      meas(100);
      chk("low_idle", dout, 5'h1f);
      bus(1, `DLS_OFS_CLEAR, 32'h3);
      meas(95);
      chk("low_fail", dout, 5'h0a);
      bus(1, `DLS_OFS_CTRL, 32'h6b);
      bus(1, `DLS_OFS_CLEAR, 32'h3);
      meas(100);
      chk("drive_off", dout, 5'h0a);
      bus(1, `DLS_OFS_CTRL, 32'h67);
      pol <= 1'b0;
      $display("test polarity done");
   endtask

   task automatic t_pulse;
      bus(1, `DLS_OFS_PULSE_TIME, 32'h3);
      bus(1, `DLS_OFS_CTRL, 32'h77);
      bus(1, `DLS_OFS_CLEAR, 32'h3);
      meas(94);
      chk("pulse_on", dout, 5'h15);
      repeat (8) @(posedge clk_i);
      chk("pulse_held", dout, 5'h15);
      repeat (10) @(posedge clk_i);
      chk("pulse_end", dout, 5'h00);
      $display("test pulse done");
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_bins;
      t_latch;
      t_pol;
      t_pulse;
      tally_and_finish;
   end
endmodule // dls_limit_sort_tb
